// *** inc/rsg_pkg.sv ***
// Functional notes
// - Method selector 0 means duration segments, 1 means ramp grade; 0 after reset.
// - Duration mode: setpoint reaches each segment target exactly when its time expires.
// - Ramp mode: setpoint moves toward target at grade per hour or per minute.
// - Time unit hh:mm by default (grade per hour); mm:ss gives grade per minute.
// - A soak segment takes a time, not a grade, even in ramp mode.
// - Start code 0: begin at starting setpoint, reach target over segment 1 time.
// - Start code 2: begin at current value, follow segment 1 time.
// - Start code 2 is not offered in ramp mode.
// - Start code 1: follow segment 1 ramp from current value if inside the ramp span, shortening remaining time; else begin at starting setpoint.
// - PID group follows the active measured-value zone; at most seven zones.
// - Alternatively the PID group is chosen per program segment.
// - After reset only zone 1 is used: group 1 over the whole range.
// - With three zones: group 1 below point 1, group 2 between points 1 and 2, group 3 above.
package rsg_pkg;
	localparam int unsigned CLK_HZ     = 50_000_000;
	localparam int unsigned SEC_S      = 1;
	localparam int unsigned SEC_CYCLES = CLK_HZ * SEC_S;
	localparam logic [15:0] SUBUNITS   = 16'h003C;
	localparam logic [5:0]  MIN_LAST   = 6'h3B;
	localparam logic [5:0]  DIV_BITS   = 6'h20;

	localparam logic [7:0]  A_CTRL = 8'h00;
	localparam logic [7:0]  A_CMD  = 8'h01;
	localparam logic [7:0]  A_SSP  = 8'h02;
	localparam logic [7:0]  A_NSEG = 8'h03;
	localparam logic [7:0]  A_REF  = 8'h08;
	localparam logic [7:0]  A_STAT = 8'h10;
	localparam logic [7:0]  A_SP   = 8'h11;
	localparam logic [7:0]  A_REM  = 8'h12;
	localparam logic [7:0]  A_PID  = 8'h13;
	localparam logic [7:0]  A_SEG  = 8'h40;

	localparam int unsigned F_METHOD = 0;
	localparam int unsigned F_UNIT   = 1;
	localparam int unsigned F_STC    = 2;
	localparam int unsigned F_PIDSEG = 4;
	localparam int unsigned F_ZONE   = 5;
	localparam int unsigned C_START  = 0;
	localparam int unsigned C_STOP   = 1;
	localparam int unsigned NREF     = 6;

	localparam logic [2:0]  ZONE_RST = 3'h1;
	localparam logic [2:0]  PID_RST  = 3'h1;
	localparam logic [15:0] SSP_RST  = 16'h0000;
	localparam logic [15:0] REF_RST  = 16'h0000;
	localparam logic [5:0]  NSEG_RST = 6'h01;

	localparam logic [1:0]  STC_ZERO = 2'h0;
	localparam logic [1:0]  STC_RAMP = 2'h1;
	localparam logic [1:0]  STC_TIME = 2'h2;
	localparam logic [1:0]  SF_TGT   = 2'h0;
	localparam logic [1:0]  SF_TIME  = 2'h1;

	typedef enum logic [5:0] {
		ST_IDLE = 6'b000001,
		ST_LOAD = 6'b000010,
		ST_DIVT = 6'b000100,
		ST_DIVQ = 6'b001000,
		ST_RUN  = 6'b010000,
		ST_NEXT = 6'b100000
	} rsg_state_t;
endpackage

// *** hdl/rsg_top.sv ***
// The implementer's own choices: the placing of the registers and the address-and-strobe port.
`timescale 1ns/1ps
module rsg_top
	import rsg_pkg::*;
#(
	parameter int unsigned NSEG    = 20,
	parameter int unsigned SEC_CYC = SEC_CYCLES
) (
	input  wire logic        mclk,
	input  wire logic        srst,
	input  wire logic [7:0]  regAddr,
	input  wire logic [15:0] regWrData,
	input  wire logic        regWr,
	input  wire logic        regRd,
	output logic      [15:0] regRdData,
	input  wire logic [15:0] pv,
	output logic      [15:0] setpoint,
	output logic      [2:0]  pidGroup,
	output logic      [4:0]  segIdx,
	output logic             running,
	output logic             progEnd
);
	if (NSEG < 1 || NSEG > 32 || SEC_CYC < 2) begin : g_chk
		$error("rsg_top: NSEG must be 1..32 and SEC_CYC at least 2");
	end
	localparam int SW = $clog2(SEC_CYC);
	function automatic logic [15:0] toMinor(input logic [15:0] t);
		return 16'(16'(t[15:8]) * SUBUNITS + 16'(t[7:0]));
	endfunction
	function automatic logic segHit(input logic [7:0] a);
		logic [7:0] off;
		off = a - A_SEG;
		return (a >= A_SEG) && !off[7] && (32'(off[6:2]) < NSEG) && (off[1:0] != 2'h3);
	endfunction
	logic             method_ff, unit_ff, pidSeg_ff, secTick_ff, minorTick_ff, up_ff, rampSeg_ff, first_ff;
	logic             running_ff, progEnd_ff, startCmd, stopCmd, inSpan, segUp, segSoak, divGe, divDone;
	logic             carry, reach;
	logic [1:0]       stc_ff, stcEff;
	logic [2:0]       zoneCnt_ff, pidGroup_ff, zone;
	logic [4:0]       seg_ff, wIdx;
	logic [5:0]       segCnt_ff, minCnt_ff, divCnt_ff;
	logic [7:0]       segOff;
	logic [15:0]      ssp_ff, sp_ff, tgt_ff, q_ff, r_ff, acc_ff, per_ff, rem_ff, divDen_ff, divRem_ff, rdData_ff;
	logic [15:0]      segTgt, segTime, segT, segDiff, sspDiff, spNext, rdMux;
	logic [16:0]      divTry, accSum, step, spUp;
	logic [31:0]      divNum_ff;
	logic [SW-1:0]    secCnt_ff;
	logic [15:0]      refPt_ff [NREF];
	logic [15:0]      tgtMem   [NSEG];
	logic [15:0]      timeMem  [NSEG];
	logic [2:0]       pidMem   [NSEG];
	rsg_state_t       st_ff;
	assign segOff   = regAddr - A_SEG;
	assign wIdx     = segOff[6:2];
	// Stop wins over a start in the same write
	assign startCmd = regWr && regAddr == A_CMD && regWrData[C_START] && !regWrData[C_STOP] && st_ff == ST_IDLE;
	assign stopCmd  = regWr && regAddr == A_CMD && regWrData[C_STOP];

	// Code 2 falls back to code 0 in ramp mode; code 3 is unused
	assign stcEff = (stc_ff == STC_RAMP) ? STC_RAMP :
		(stc_ff == STC_TIME && !method_ff) ? STC_TIME : STC_ZERO;

	// Configuration
	always_ff @(posedge mclk) begin
		if (srst) begin
			method_ff  <= 1'b0;
			unit_ff    <= 1'b0;
			stc_ff     <= STC_ZERO;
			pidSeg_ff  <= 1'b0;
			zoneCnt_ff <= ZONE_RST;
			ssp_ff     <= SSP_RST;
			segCnt_ff  <= NSEG_RST;
		end else if (regWr && regAddr == A_CTRL) begin
			method_ff  <= regWrData[F_METHOD];
			unit_ff    <= regWrData[F_UNIT];
			stc_ff     <= regWrData[F_STC +: 2];
			pidSeg_ff  <= regWrData[F_PIDSEG];
			zoneCnt_ff <= (regWrData[F_ZONE +: 3] == 3'h0) ? ZONE_RST : regWrData[F_ZONE +: 3];
		end else if (regWr && regAddr == A_SSP) begin
			ssp_ff <= regWrData;
		end else if (regWr && regAddr == A_NSEG) begin
			segCnt_ff <= (regWrData == 16'h0000) ? NSEG_RST : (32'(regWrData) > NSEG) ? 6'(NSEG) : regWrData[5:0];
		end
	end

	for (genvar i = 0; i < NREF; i++) begin : g_ref
		always_ff @(posedge mclk) begin
			if (srst) begin
				refPt_ff[i] <= REF_RST;
			end else if (regWr && regAddr == A_REF + 8'(i)) begin
				refPt_ff[i] <= regWrData;
			end
		end
	end

	// Segment table
	always_ff @(posedge mclk) begin
		if (regWr && segHit(regAddr)) begin
			case (segOff[1:0])
				SF_TGT:  tgtMem[wIdx]  <= regWrData;
				SF_TIME: timeMem[wIdx] <= regWrData;
				default: pidMem[wIdx]  <= regWrData[2:0];
			endcase
		end
	end

	// Free-running second tick, minor tick is a second (mm:ss) or a minute (hh:mm)
	always_ff @(posedge mclk) begin
		if (srst) begin
			secCnt_ff    <= '0;
			minCnt_ff    <= 6'h00;
			secTick_ff   <= 1'b0;
			minorTick_ff <= 1'b0;
		end else begin
			secTick_ff <= (secCnt_ff == SW'(SEC_CYC - 1));
			secCnt_ff  <= (secCnt_ff == SW'(SEC_CYC - 1)) ? '0 : secCnt_ff + 1'b1;
			if (secTick_ff) begin
				minCnt_ff <= (minCnt_ff == MIN_LAST) ? 6'h00 : minCnt_ff + 6'h01;
			end
			minorTick_ff <= unit_ff ? secTick_ff : (secTick_ff && minCnt_ff == MIN_LAST);
		end
	end

	assign inSpan  = (pv >= ssp_ff && pv <= tgtMem[0]) || (pv <= ssp_ff && pv >= tgtMem[0]);
	assign segTgt  = tgtMem[seg_ff];
	assign segTime = timeMem[seg_ff];
	assign segT    = toMinor(segTime);
	assign segUp   = segTgt >= sp_ff;
	assign segDiff = segUp ? segTgt - sp_ff : sp_ff - segTgt;
	assign sspDiff = (segTgt >= ssp_ff) ? segTgt - ssp_ff : ssp_ff - segTgt;
	assign segSoak = segTgt == sp_ff;

	assign divTry  = {divRem_ff, divNum_ff[31]};
	assign divGe   = divTry >= {1'b0, divDen_ff};
	assign divDone = divCnt_ff == DIV_BITS;

	// Spread the remainder evenly over the ticks so the last tick lands on target
	assign accSum = {1'b0, acc_ff} + {1'b0, r_ff};
	assign carry  = accSum >= {1'b0, per_ff};
	assign step   = {1'b0, q_ff} + {16'h0000, carry};
	assign spUp   = {1'b0, sp_ff} + step;
	assign reach  = up_ff ? (spUp >= {1'b0, tgt_ff}) : (step >= {1'b0, 16'(sp_ff - tgt_ff)});
	assign spNext = up_ff ? spUp[15:0] : 16'(sp_ff - step[15:0]);

	// Program engine
	always_ff @(posedge mclk) begin
		if (srst) begin
			st_ff      <= ST_IDLE;
			seg_ff     <= 5'h00;
			sp_ff      <= SSP_RST;
			tgt_ff     <= SSP_RST;
			q_ff       <= 16'h0000;
			r_ff       <= 16'h0000;
			acc_ff     <= 16'h0000;
			per_ff     <= 16'h0001;
			rem_ff     <= 16'h0000;
			up_ff      <= 1'b1;
			rampSeg_ff <= 1'b0;
			first_ff   <= 1'b0;
			divNum_ff  <= 32'h0000_0000;
			divDen_ff  <= 16'h0001;
			divRem_ff  <= 16'h0000;
			divCnt_ff  <= 6'h00;
			running_ff <= 1'b0;
			progEnd_ff <= 1'b0;
		end else begin
			progEnd_ff <= 1'b0;
			if ((st_ff == ST_DIVT || st_ff == ST_DIVQ) && !divDone) begin
				divRem_ff <= divGe ? 16'(divTry - {1'b0, divDen_ff}) : divTry[15:0];
				divNum_ff <= {divNum_ff[30:0], divGe};
				divCnt_ff <= divCnt_ff + 6'h01;
			end
			if (stopCmd) begin
				st_ff      <= ST_IDLE;
				running_ff <= 1'b0;
			end else begin
				unique case (st_ff)
					ST_IDLE: begin
						if (startCmd) begin
							seg_ff     <= 5'h00;
							first_ff   <= 1'b1;
							running_ff <= 1'b1;
							st_ff      <= ST_LOAD;
							sp_ff <= (stcEff == STC_TIME || (stcEff == STC_RAMP && inSpan)) ?
								pv : ssp_ff;
						end
					end
					ST_LOAD: begin
						tgt_ff     <= segTgt;
						up_ff      <= segUp;
						acc_ff     <= 16'h0000;
						divCnt_ff  <= 6'h00;
						divRem_ff  <= 16'h0000;
						rampSeg_ff <= method_ff && !segSoak;
						if (method_ff && !segSoak) begin
							divNum_ff <= {16'h0000, segTime};
							divDen_ff <= SUBUNITS;
							rem_ff    <= 16'h0000;
							st_ff     <= ST_DIVQ;
						end else if (segT == 16'h0000) begin
							sp_ff  <= segTgt;
							rem_ff <= 16'h0000;
							st_ff  <= ST_NEXT;
						end else if (first_ff && stcEff == STC_RAMP && sspDiff != 16'h0000) begin
							divNum_ff <= segT * segDiff;
							divDen_ff <= sspDiff;
							st_ff     <= ST_DIVT;
						end else begin
							divNum_ff <= {16'h0000, segDiff};
							divDen_ff <= segT;
							rem_ff    <= segT;
							st_ff     <= ST_DIVQ;
						end
					end
					ST_DIVT: begin
						if (divDone) begin
							if (divNum_ff[15:0] == 16'h0000) begin
								sp_ff  <= tgt_ff;
								rem_ff <= 16'h0000;
								st_ff  <= ST_NEXT;
							end else begin
								rem_ff    <= divNum_ff[15:0];
								divDen_ff <= divNum_ff[15:0];
								divNum_ff <= {16'h0000, up_ff ? 16'(tgt_ff - sp_ff) : 16'(sp_ff - tgt_ff)};
								divRem_ff <= 16'h0000;
								divCnt_ff <= 6'h00;
								st_ff     <= ST_DIVQ;
							end
						end
					end
					ST_DIVQ: begin
						if (divDone) begin
							q_ff   <= divNum_ff[15:0];
							r_ff   <= divRem_ff;
							per_ff <= divDen_ff;
							st_ff  <= ST_RUN;
						end
					end
					ST_RUN: begin
						if (minorTick_ff) begin
							acc_ff <= carry ? 16'(accSum - {1'b0, per_ff}) : accSum[15:0];
							if (rampSeg_ff) begin
								if (reach) begin
									sp_ff <= tgt_ff;
									st_ff <= ST_NEXT;
								end else begin
									sp_ff <= spNext;
								end
							end else begin
								rem_ff <= rem_ff - 16'h0001;
								if (rem_ff == 16'h0001) begin
									sp_ff <= tgt_ff;
									st_ff <= ST_NEXT;
								end else begin
									sp_ff <= spNext;
								end
							end
						end
					end
					ST_NEXT: begin
						first_ff <= 1'b0;
						if ({1'b0, seg_ff} + 6'h01 >= segCnt_ff) begin
							st_ff      <= ST_IDLE;
							running_ff <= 1'b0;
							progEnd_ff <= 1'b1;
						end else begin
							seg_ff <= seg_ff + 5'h01;
							st_ff  <= ST_LOAD;
						end
					end
				endcase
			end
		end
	end

	// Zone index counts the reference points at or below the measured value among the first zoneCnt_ff - 1 points
	always_comb begin
		zone = 3'h0;
		for (int i = 0; i < NREF; i++) begin
			if (3'(i) < zoneCnt_ff - 3'h1 && pv >= refPt_ff[i]) begin
				zone = zone + 3'h1;
			end
		end
	end

	always_ff @(posedge mclk) begin
		if (srst) begin
			pidGroup_ff <= PID_RST;
		end else if (pidSeg_ff && running_ff) begin
			pidGroup_ff <= (pidMem[seg_ff] == 3'h0) ? PID_RST : pidMem[seg_ff];
		end else begin
			pidGroup_ff <= zone + 3'h1;
		end
	end

	// Register read
	always_comb begin
		rdMux = 16'h0000;
		if (segHit(regAddr)) begin
			rdMux = (segOff[1:0] == SF_TGT) ? tgtMem[wIdx] :
				(segOff[1:0] == SF_TIME) ? timeMem[wIdx] : {13'h0000, pidMem[wIdx]};
		end else if (regAddr >= A_REF && regAddr < A_REF + 8'(NREF)) begin
			rdMux = refPt_ff[3'(regAddr - A_REF)];
		end else begin
			case (regAddr)
				A_CTRL:  rdMux = {8'h00, zoneCnt_ff, pidSeg_ff, stc_ff, unit_ff, method_ff};
				A_SSP:   rdMux = ssp_ff;
				A_NSEG:  rdMux = {10'h000, segCnt_ff};
				A_STAT:  rdMux = {3'h0, seg_ff, 7'h00, running_ff};
				A_SP:    rdMux = sp_ff;
				A_REM:   rdMux = rem_ff;
				A_PID:   rdMux = {13'h0000, pidGroup_ff};
				default: rdMux = 16'h0000;
			endcase
		end
	end

	always_ff @(posedge mclk) begin
		if (srst) begin
			rdData_ff <= 16'h0000;
		end else begin
			rdData_ff <= regRd ? rdMux : 16'h0000;
		end
	end

	assign regRdData = rdData_ff;
	assign setpoint  = sp_ff;
	assign pidGroup  = pidGroup_ff;
	assign segIdx    = seg_ff;
	assign running   = running_ff;
	assign progEnd   = progEnd_ff;

	default clocking cb @(posedge mclk); endclocking
	default disable iff (srst);
	a_method_reset: assert property (disable iff (1'b0) srst |=> !method_ff && !unit_ff)
		else $error("method or unit not cleared by reset");
	a_dur_target: assert property (st_ff == ST_RUN && !rampSeg_ff && minorTick_ff && rem_ff == 16'h0001 && !stopCmd
		|=> st_ff == ST_NEXT && sp_ff == tgt_ff)
		else $error("duration segment ended off target");
	a_ramp_still: assert property (st_ff == ST_RUN && rampSeg_ff && !minorTick_ff |=> sp_ff == $past(sp_ff))
		else $error("ramp setpoint moved without a tick");
	a_tick_period: assert property (secTick_ff |-> $past(secCnt_ff) == SW'(SEC_CYC - 1))
		else $error("second tick at wrong count");
	a_minor_unit: assert property (minorTick_ff |-> $past(secTick_ff))
		else $error("minor tick without second tick");
	a_soak_time: assert property (st_ff == ST_LOAD && segSoak && !stopCmd |=> !rampSeg_ff)
		else $error("soak segment treated as ramp");
	a_start_zero: assert property (startCmd && stcEff == STC_ZERO |=> sp_ff == $past(ssp_ff))
		else $error("code 0 start not at starting setpoint");
	a_start_pv: assert property (startCmd && stcEff == STC_TIME |=> sp_ff == $past(pv))
		else $error("code 2 start not at current value");
	a_no_code2: assert property (startCmd && method_ff && stc_ff == STC_TIME |=> sp_ff == $past(ssp_ff))
		else $error("code 2 in ramp mode did not start at starting setpoint");
	a_ramp_entry: assert property (startCmd && stcEff == STC_RAMP
		|=> sp_ff == ($past(inSpan) ? $past(pv) : $past(ssp_ff)))
		else $error("code 1 entry point wrong");
	a_zone_limit: assert property (!pidSeg_ff |=> pidGroup_ff <= $past(zoneCnt_ff) && pidGroup_ff != 3'h0)
		else $error("group beyond configured zones");
	a_zone_one: assert property (zoneCnt_ff == 3'h1 && !pidSeg_ff |=> pidGroup_ff == 3'h1)
		else $error("single zone did not give group 1");
	a_zone_low: assert property (!pidSeg_ff && zoneCnt_ff >= 3'h3 && pv < refPt_ff[0] |=> pidGroup_ff == 3'h1)
		else $error("below point 1 did not give group 1");
	a_zone_mid: assert property (!pidSeg_ff && zoneCnt_ff == 3'h3 && pv >= refPt_ff[0] && pv < refPt_ff[1]
		|=> pidGroup_ff == 3'h2)
		else $error("between points did not give group 2");
	c_ramp_entry: cover property (startCmd && stcEff == STC_RAMP && inSpan);
	c_ramp_step: cover property (st_ff == ST_RUN && rampSeg_ff && minorTick_ff);
	c_prog_end: cover property (progEnd_ff);
	c_group3: cover property (pidGroup_ff == 3'h3);
endmodule

// *** verif/rsg_plant_model.sv ***
`timescale 1ns/1ps
module rsg_plant_model (
	input  wire logic        mclk,
	input  wire logic        srst,
	input  wire logic [15:0] pvGoal,
	input  wire logic [15:0] pvSlew,
	output logic      [15:0] pv
);
	// Measured value creeps toward the goal; slew 0 lets it settle at once
	always_ff @(posedge mclk) begin
		if (srst)
			pv <= 16'h0000;
		else if (pvSlew == 16'h0000 || pv == pvGoal)
			pv <= pvGoal;
		else if (pv < pvGoal)
			pv <= (pvGoal - pv < pvSlew) ? pvGoal : pv + pvSlew;
		else
			pv <= (pv - pvGoal < pvSlew) ? pvGoal : pv - pvSlew;
	end
endmodule

// *** verif/tb_top.sv ***
`timescale 1ns/1ps
module tb_top import rsg_pkg::*;;
	logic        mclk, srst, regWr, regRd, running, progEnd;
	logic [7:0]  regAddr;
	logic [15:0] regWrData, regRdData, pv, setpoint, pvGoal, pvSlew, rd;
	logic [2:0]  pidGroup;
	logic [4:0]  segIdx;
	int          miscompares, compares, cyc, t0, el;
	logic [15:0] zc [8] = '{16'h0020, 16'h0060, 16'h0060, 16'h0060, 16'h0060, 16'h00E0, 16'h00E0, 16'h00E0};
	logic [15:0] zp [8] = '{16'd650, 16'd99, 16'd100, 16'd250, 16'd650, 16'd350, 16'd599, 16'd650};
	logic [2:0]  ze [8] = '{3'd1, 3'd1, 3'd2, 3'd3, 3'd3, 3'd4, 3'd6, 3'd7};

	rsg_top #(.NSEG(20), .SEC_CYC(10)) rsg_top_inst (
		.mclk(mclk), .srst(srst), .regAddr(regAddr), .regWrData(regWrData), .regWr(regWr),
		.regRd(regRd), .regRdData(regRdData), .pv(pv), .setpoint(setpoint), .pidGroup(pidGroup),
		.segIdx(segIdx), .running(running), .progEnd(progEnd));
	rsg_plant_model rsg_plant_model_inst (
		.mclk(mclk), .srst(srst), .pvGoal(pvGoal), .pvSlew(pvSlew), .pv(pv));

	always #10 mclk = ~mclk;

	task stop_test();
		$display("compares=%0d miscompares=%0d", compares, miscompares);
		if (miscompares == 0 && compares > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask

	// Long ramp runs about 6200 cycles; the whole run stays far below this
	always @(posedge mclk) begin
		cyc++;
		if (cyc == 20000) begin
			miscompares++;
			stop_test();
		end
	end

	task chk(input logic [15:0] g, input logic [15:0] e, input string m);
		compares++;
		if (g !== e) begin
			miscompares++;
			$display("MISMATCH t=%0t %s got %h exp %h", $time, m, g, e);
		end
	endtask

	task chkRange(input logic [31:0] v, input int lo, input int hi, input string m);
		compares++;
		if ((v >= lo && v <= hi) !== 1'b1) begin
			miscompares++;
			$display("MISMATCH t=%0t %s got %0d not in %0d..%0d", $time, m, v, lo, hi);
		end
	endtask

	task wr(input logic [7:0] a, input logic [15:0] d);
		@(posedge mclk);
		regWr <= 1'b1;
		regAddr <= a;
		regWrData <= d;
		@(posedge mclk);
		regWr <= 1'b0;
	endtask

	// Read data stands only in the cycle after the strobe
	task rdc(input logic [7:0] a, input logic [15:0] e, input string m);
		@(posedge mclk);
		regRd <= 1'b1;
		regAddr <= a;
		@(posedge mclk);
		regRd <= 1'b0;
		#1;
		rd = regRdData;
		chk(rd, e, m);
	endtask

	task seg(input int n, input logic [15:0] tgt, input logic [15:0] tm, input logic [15:0] pid);
		wr(8'(A_SEG + 4 * n), tgt);
		wr(8'(A_SEG + 4 * n + 1), tm);
		wr(8'(A_SEG + 4 * n + 2), pid);
	endtask

	task run(input logic [15:0] ctrl, input logic [15:0] ssp, input logic [15:0] nseg);
		wr(A_SSP, ssp);
		wr(A_NSEG, nseg);
		wr(A_CTRL, ctrl);
		t0 = cyc;
		wr(A_CMD, 16'h0001);
		repeat (3) @(posedge mclk);
		#1;
	endtask

	task waitEnd();
		for (int i = 0; i < 8000; i++) begin
			@(posedge mclk);
			#1;
			if (progEnd === 1'b1)
				break;
		end
		el = cyc - t0;
		chk({15'h0000, progEnd}, 16'h0001, "program end pulse");
	endtask

	task waitSeg();
		for (int i = 0; i < 8000; i++) begin
			@(posedge mclk);
			#1;
			if (segIdx === 5'd1)
				break;
		end
	endtask

	task halt();
		wr(A_CMD, 16'h0002);
		repeat (2) @(posedge mclk);
		#1;
		chk({15'h0000, running}, 16'h0000, "stopped");
	endtask

	initial begin
		mclk = 1'b0;
		srst = 1'b1;
		regWr = 1'b0;
		regRd = 1'b0;
		regAddr = 8'h00;
		regWrData = 16'h0000;
		pvGoal = 16'h0000;
		pvSlew = 16'h0000;
		miscompares = 0;
		compares = 0;
		cyc = 0;
		repeat (8) @(posedge mclk);
		srst <= 1'b0;
		@(posedge mclk);
		rdc(A_CTRL, 16'h0020, "ctrl reset");
		rdc(A_SSP, 16'h0000, "ssp reset");
		rdc(A_NSEG, 16'h0001, "nseg reset");
		rdc(A_REF, 16'h0000, "ref reset");
		rdc(8'h04, 16'h0000, "unmapped read");
		rdc(8'h43, 16'h0000, "unmapped seg word");
		chk({13'h0000, pidGroup}, 16'h0001, "pid reset");
		chk(setpoint, 16'h0000, "sp reset");
		for (int i = 0; i < 6; i++)
			wr(8'(A_REF + i), 16'(100 * (i + 1)));
		for (int i = 0; i < 8; i++) begin
			wr(A_CTRL, zc[i]);
			pvGoal <= zp[i];
			repeat (4) @(posedge mclk);
			#1;
			chk({13'h0000, pidGroup}, {13'h0000, ze[i]}, "zone group");
		end
		pvGoal <= 16'h0000;
		// Duration, mm:ss, code 0, per-segment PID, then a soak
		seg(0, 16'd200, 16'h0003, 16'h0005);
		seg(1, 16'd200, 16'h0002, 16'h0002);
		run(16'h0032, 16'd100, 16'h0002);
		chk(setpoint, 16'd100, "code0 start");
		chk({13'h0000, pidGroup}, 16'h0005, "seg pid 1");
		rdc(A_STAT, 16'h0001, "stat running");
		rdc(A_SP, 16'd100, "sp register");
		waitSeg();
		chk(setpoint, 16'd200, "target at expiry");
		chk({11'h000, segIdx}, 16'h0001, "segment index");
		repeat (2) @(posedge mclk);
		#1;
		chk({13'h0000, pidGroup}, 16'h0002, "seg pid 2");
		waitEnd();
		chkRange(el, 95, 140, "duration run time");
		repeat (2) @(posedge mclk);
		#1;
		chk({15'h0000, running}, 16'h0000, "idle after end");
		chk(setpoint, 16'd200, "hold last target");
		// Ramp, mm:ss: 5 per minute from 50 to 100, then a 16 s soak
		seg(0, 16'd100, 16'd5, 16'h0001);
		seg(1, 16'd100, 16'h0010, 16'h0001);
		run(16'h0023, 16'd50, 16'h0002);
		repeat (3000) @(posedge mclk);
		#1;
		chkRange(setpoint, 71, 77, "ramp midway");
		waitSeg();
		chk(setpoint, 16'd100, "ramp reached");
		waitEnd();
		chkRange(el, 6150, 6320, "ramp plus soak time");
		// Ramp, hh:mm: 600 per hour steps 10 per minute; minute tick is free-running, so time from the first step
		seg(0, 16'd20, 16'd600, 16'h0001);
		run(16'h0021, 16'd0, 16'h0001);
		while (setpoint === 16'h0000) begin
			@(posedge mclk);
			#1;
		end
		chk(setpoint, 16'd10, "hourly first step");
		t0 = cyc;
		waitEnd();
		chkRange(el, 598, 604, "hourly step spacing");
		chk(setpoint, 16'd20, "hourly target");
		// Code 2 in duration mode starts at the measured value
		pvGoal <= 16'd150;
		seg(0, 16'd200, 16'h0003, 16'h0001);
		run(16'h002A, 16'd0, 16'h0001);
		chk(setpoint, 16'd150, "code2 start");
		waitEnd();
		chkRange(el, 55, 85, "code2 time");
		chk(setpoint, 16'd200, "code2 target");
		// Code 2 refused in ramp mode: behaves as code 0
		run(16'h0029, 16'd30, 16'h0001);
		chk(setpoint, 16'd30, "code2 ramp start");
		halt();
		// Code 1 inside the ramp span: half the time remains
		seg(0, 16'd200, 16'h0014, 16'h0001);
		run(16'h0026, 16'd100, 16'h0001);
		chk(setpoint, 16'd150, "code1 entry");
		waitEnd();
		chkRange(el, 140, 200, "code1 shortened");
		// Code 1 outside the span starts at the ramp beginning
		pvGoal <= 16'd50;
		repeat (2) @(posedge mclk);
		run(16'h0024, 16'd100, 16'h0001);
		chk(setpoint, 16'd100, "code1 outside");
		halt();
		stop_test();
	end
endmodule
